// ===== include/sram_defs.svh
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

// Clock and flow-through access figures
`define CLK_PERIOD_PS 10000
`define CLK_TO_VALID_PS 6500
// Longest time rounds down, but never below one cycle
`define CLK_TO_VALID_CYC \
  (((`CLK_TO_VALID_PS / `CLK_PERIOD_PS) > 0) ? \
   (`CLK_TO_VALID_PS / `CLK_PERIOD_PS) : 1)

// Sleep entry and recovery, in clock cycles
`define SLEEP_ENTRY_CYC 2'h2
`define SLEEP_EXIT_CYC 2'h2
`define SLEEP_CNT_FIRST 2'h1

// Burst counter layout
`define BURST_LO_W 2
`define BURST_CNT_RST 2'h0
`define BURST_CNT_STEP 2'h1

// Lane layout
`define LANE_W 8

`endif

// ===== include/sram_pkg.sv
package sram_pkg;

  // Sleep sequencing states
  typedef enum logic [1:0] {
    st_run,
    st_enter,
    st_sleep,
    st_leave
  } sleep_st_t;

  // Low address bits of a burst beat, step beats after the start
  function automatic logic [1:0] burst_lo(input logic [1:0] start,
                                          input logic [1:0] step,
                                          input logic interleave);
    logic [1:0] sum;
    sum = 2'(start + step);
    return interleave ? (start ^ step) : sum;
  endfunction

  // Byte-lane merge: selected lanes take the new data
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] lane,
                                             input int lw);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < lw; b++) begin
        if (lane[i]) begin
          res[i * lw + b] = new_w[i * lw + b];
        end
      end
    end
    return res;
  endfunction

endpackage

// ===== include/wr_stream_if.sv
// One write beat: address, data, parity and active-high lane mask
interface wr_stream_if #(
  parameter int AW = 10,
  parameter int NB = 4
);
  logic valid;
  logic ready;
  logic [AW-1:0] addr;
  logic [8*NB-1:0] data;
  logic [NB-1:0] par;
  logic [NB-1:0] lane;

  modport src(output valid, output addr, output data, output par,
              output lane, input ready);
  modport snk(input valid, input addr, input data, input par,
              input lane, output ready);
endinterface

// ===== logic/sram_port.sv
// Operation
// - Inputs taken on rising edge; qualifier high freezes access and burst state.
// - Qualified load with all selects latches address, starts read/write.
// - Read data appear in the cycle after the command edge.
// - After a read command, drivers on only while output enable low.
// - Load with any select inactive deselects; outputs go high-Z.
// - A new command is accepted on the edge after any operation.
// - Two-bit burst counter, up to four beats, wraps in group.
// - Strap low gives linear order, high or floating interleaved.
// - Interleaved beats are start XOR 01, 10, 11.
// - Linear beats add one modulo four to the low bits.
// - Step input high advances burst, ignoring selects and write.
// - Write-select captured at burst start holds for all beats.
// - Writes tristate the bus; data captured at next edge.
// - Active-low lane strobes gate each byte and its parity.
// - Sleep entry two cycles after request, exit two; data kept.
// - Accesses pending at sleep entry are dropped.
// - Comes up deselected with outputs high-Z.
// - Outputs high-Z in first cycle after leaving deselect.
`include "sram_defs.svh"

module sram_port #(
  parameter int AW = 10,
  parameter int NB = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_qualify_n,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_c_n,
  input wire logic burst_step_or_load,
  input wire logic wr_sel_n,
  input wire logic [NB-1:0] byte_lane_wr_n,
  input wire logic [AW-1:0] addr,
  input wire logic out_en_n,
  input wire logic sleep_req,
  input wire logic burst_order_strap,
  input wire logic [8*NB-1:0] data_i,
  output logic [8*NB-1:0] data_o,
  output logic data_oe,
  input wire logic [NB-1:0] parity_i,
  output logic [NB-1:0] parity_o,
  output logic parity_oe,
  output logic sleeping
);
  localparam int HW = AW - `BURST_LO_W;

  // Synchronisers for the asynchronous pins and the strap
  logic oe_s1;
  logic oe_s2;
  logic zz_s1;
  logic zz_s2;
  logic strap_s1;
  logic strap_s2;

  // Sleep sequencing state
  sram_pkg::sleep_st_t st;
  sram_pkg::sleep_st_t next_st;
  logic [1:0] scnt;
  logic [1:0] next_scnt;

  // Access and burst state
  logic active;
  logic next_active;
  logic is_wr;
  logic next_is_wr;
  logic [HW-1:0] base;
  logic [HW-1:0] next_base;
  logic [1:0] start_lo;
  logic [1:0] next_start_lo;
  logic [1:0] lo;
  logic [1:0] next_lo;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic wr_pend;
  logic next_wr_pend;
  logic [AW-1:0] wr_addr;
  logic [AW-1:0] next_wr_addr;
  logic [NB-1:0] wr_lane;
  logic [NB-1:0] next_wr_lane;
  logic rd_cycle;
  logic next_rd_cycle;
  logic desel;
  logic next_desel;
  logic emerge;
  logic next_emerge;
  logic next_data_oe;
  logic sleeping_q;

  // Per-edge decode
  logic take;
  logic stall;
  logic beat;
  logic re;
  logic [AW-1:0] beat_addr;
  logic sel_all;

  wr_stream_if #(.AW(AW), .NB(NB)) wr_in ();
  wr_stream_if #(.AW(AW), .NB(NB)) wr_out ();

  // Two flops before any logic looks at an asynchronous level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_s1 <= 1'b1;
      oe_s2 <= 1'b1;
      zz_s1 <= 1'b0;
      zz_s2 <= 1'b0;
      strap_s1 <= 1'b1;
      strap_s2 <= 1'b1;
    end else begin
      oe_s1 <= out_en_n;
      oe_s2 <= oe_s1;
      zz_s1 <= sleep_req;
      zz_s2 <= zz_s1;
      strap_s1 <= burst_order_strap;
      strap_s2 <= strap_s1;
    end
  end

  // Sleep entry and exit each take a fixed number of cycles
  always_comb begin
    next_st = st;
    next_scnt = scnt;
    unique case (st)
      sram_pkg::st_run: begin
        if (zz_s2) begin
          next_st = sram_pkg::st_enter;
          next_scnt = `SLEEP_CNT_FIRST;
        end
      end
      sram_pkg::st_enter: begin
        if (scnt == `SLEEP_ENTRY_CYC - `SLEEP_CNT_FIRST) begin
          next_st = sram_pkg::st_sleep;
        end else begin
          next_scnt = 2'(scnt + `SLEEP_CNT_FIRST);
        end
      end
      sram_pkg::st_sleep: begin
        if (!zz_s2) begin
          next_st = sram_pkg::st_leave;
          next_scnt = `SLEEP_CNT_FIRST;
        end
      end
      sram_pkg::st_leave: begin
        if (scnt == `SLEEP_EXIT_CYC - `SLEEP_CNT_FIRST) begin
          next_st = sram_pkg::st_run;
        end else begin
          next_scnt = 2'(scnt + `SLEEP_CNT_FIRST);
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= sram_pkg::st_run;
      scnt <= `BURST_CNT_RST;
      sleeping_q <= 1'b0;
    end else begin
      st <= next_st;
      scnt <= next_scnt;
      sleeping_q <= (next_st == sram_pkg::st_sleep);
    end
  end

  // A refused write beat stalls the port like a masked clock
  assign stall = wr_pend && !wr_in.ready;
  assign take = !clk_qualify_n && (st == sram_pkg::st_run) && !stall;
  assign sel_all = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;

  // Write data for the previous beat are pushed at this edge
  assign wr_in.valid = wr_pend && take;
  assign wr_in.addr = wr_addr;
  assign wr_in.data = data_i;
  assign wr_in.par = parity_i;
  assign wr_in.lane = ~wr_lane;

  // Command decode, burst counter and output-enable planning
  always_comb begin
    next_active = active;
    next_is_wr = is_wr;
    next_base = base;
    next_start_lo = start_lo;
    next_lo = lo;
    next_cnt = cnt;
    next_wr_pend = wr_pend;
    next_wr_addr = wr_addr;
    next_wr_lane = wr_lane;
    next_rd_cycle = rd_cycle;
    next_desel = desel;
    next_emerge = emerge;
    beat = 1'b0;
    beat_addr = addr;
    if (st != sram_pkg::st_run) begin
      // Anything in flight is abandoned on the way into sleep
      next_active = 1'b0;
      next_wr_pend = 1'b0;
      next_rd_cycle = 1'b0;
      next_desel = 1'b1;
      next_emerge = 1'b0;
    end else if (take) begin
      next_wr_pend = 1'b0;
      next_rd_cycle = 1'b0;
      next_emerge = 1'b0;
      if (!burst_step_or_load) begin
        if (sel_all) begin
          next_active = 1'b1;
          next_is_wr = !wr_sel_n;
          next_base = addr[AW-1:`BURST_LO_W];
          next_start_lo = addr[`BURST_LO_W-1:0];
          next_lo = addr[`BURST_LO_W-1:0];
          next_cnt = `BURST_CNT_RST;
          next_desel = 1'b0;
          next_emerge = desel;
          beat = 1'b1;
        end else begin
          next_active = 1'b0;
          next_desel = 1'b1;
        end
      end else if (active) begin
        // Step ignores selects and write-select entirely
        next_cnt = 2'(cnt + `BURST_CNT_STEP);
        next_lo = sram_pkg::burst_lo(start_lo, next_cnt, strap_s2);
        beat = 1'b1;
        beat_addr = {base, next_lo};
      end
      if (beat && next_is_wr) begin
        next_wr_pend = 1'b1;
        next_wr_addr = beat_addr;
        next_wr_lane = byte_lane_wr_n;
      end else if (beat) begin
        next_rd_cycle = 1'b1;
      end
    end
    // Drivers follow output enable only in a read data cycle
    next_data_oe = next_rd_cycle && !next_emerge && !oe_s2;
  end

  assign re = beat && !next_is_wr && take;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Power-up state is deselected with the bus released
      active <= 1'b0;
      is_wr <= 1'b0;
      base <= '0;
      start_lo <= `BURST_CNT_RST;
      lo <= `BURST_CNT_RST;
      cnt <= `BURST_CNT_RST;
      wr_pend <= 1'b0;
      wr_addr <= '0;
      wr_lane <= '1;
      rd_cycle <= 1'b0;
      desel <= 1'b1;
      emerge <= 1'b0;
      data_oe <= 1'b0;
    end else begin
      active <= next_active;
      is_wr <= next_is_wr;
      base <= next_base;
      start_lo <= next_start_lo;
      lo <= next_lo;
      cnt <= next_cnt;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      wr_lane <= next_wr_lane;
      rd_cycle <= next_rd_cycle;
      desel <= next_desel;
      emerge <= next_emerge;
      data_oe <= next_data_oe;
    end
  end

  // Two-entry buffer; writes reach it only while the array runs, so it falls through
  sram_wr_buf #(.AW(AW), .NB(NB)) u_buf (
    .clk(clk),
    .rst(rst),
    .up(wr_in.snk),
    .dn(wr_out.src)
  );

  // Flow-through: array read is registered on the command edge
  sram_store #(.AW(AW), .NB(NB)) u_store (
    .clk(clk),
    .rst(rst),
    .drain_en(st == sram_pkg::st_run),
    .wr(wr_out.snk),
    .re(re),
    .raddr(beat_addr),
    .rdata(data_o),
    .rpar(parity_o)
  );

  assign parity_oe = data_oe;
  assign sleeping = sleeping_q;

  a_stall_hold: assert property (@(posedge clk) disable iff (rst)
    (clk_qualify_n && st == sram_pkg::st_run && !$past(rst))
    |=> ($stable(active) && $stable(lo) && $stable(cnt)))
    else $error("state moved on a masked edge");

  a_load_read: assert property (@(posedge clk) disable iff (rst)
    (take && !burst_step_or_load && sel_all && wr_sel_n)
    |=> (rd_cycle && active && !is_wr && lo == $past(addr[1:0])))
    else $error("read load not started");

  a_drive_cause: assert property (@(posedge clk) disable iff (rst)
    data_oe |-> (rd_cycle && !emerge && !$past(oe_s2)))
    else $error("drivers on outside a read data cycle");

  a_desel_tri: assert property (@(posedge clk) disable iff (rst)
    (take && !burst_step_or_load && !sel_all)
    |=> (!data_oe && !active))
    else $error("deselect left outputs driven");

  a_order_ilv: assert property (@(posedge clk) disable iff (rst)
    (take && burst_step_or_load && active && strap_s2)
    |=> (lo == ($past(start_lo) ^ 2'($past(cnt) + 2'h1))))
    else $error("interleaved beat address wrong");

  a_order_lin: assert property (@(posedge clk) disable iff (rst)
    (take && burst_step_or_load && active && !strap_s2)
    |=> (lo == 2'($past(lo) + 2'h1)))
    else $error("linear beat address wrong");

  a_write_type: assert property (@(posedge clk) disable iff (rst)
    (take && burst_step_or_load && active)
    |=> ($stable(is_wr) && (wr_pend == is_wr) && (rd_cycle == !is_wr)))
    else $error("burst changed access type");

  a_write_tri: assert property (@(posedge clk) disable iff (rst)
    wr_pend |-> !data_oe)
    else $error("bus driven during write data cycle");

  a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
    (st == sram_pkg::st_run && zz_s2)
    |=> (st == sram_pkg::st_enter) ##1 (st == sram_pkg::st_sleep))
    else $error("sleep entry not two cycles");

  a_sleep_drop: assert property (@(posedge clk) disable iff (rst)
    (st == sram_pkg::st_sleep) |-> (!active && !wr_pend && !data_oe))
    else $error("access survived sleep entry");

  a_emerge_tri: assert property (@(posedge clk) disable iff (rst)
    (take && !burst_step_or_load && sel_all && desel)
    |=> !data_oe)
    else $error("driven on first cycle after deselect");
endmodule

// ===== logic/sram_store.sv
`include "sram_defs.svh"

module sram_store #(
  parameter int AW = 10,
  parameter int NB = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic drain_en,
  wr_stream_if.snk wr,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [8*NB-1:0] rdata,
  output logic [NB-1:0] rpar
);
  logic [8*NB-1:0] arr [2**AW];
  logic [NB-1:0] par_arr [2**AW];
  logic [8*NB-1:0] next_rdata;
  logic [NB-1:0] next_rpar;
  logic do_wr;

  // Drain stalls while asleep; contents are kept throughout
  assign wr.ready = drain_en;
  assign do_wr = wr.valid && drain_en;

  // Write-first on a same-address collision keeps reads coherent
  always_comb begin
    next_rdata = rdata;
    next_rpar = rpar;
    if (re) begin
      next_rdata = arr[raddr];
      next_rpar = par_arr[raddr];
      if (do_wr && (wr.addr == raddr)) begin
        next_rdata = sram_pkg::lane_merge(arr[raddr], wr.data, wr.lane,
                                          `LANE_W);
        next_rpar = (par_arr[raddr] & ~wr.lane) | (wr.par & wr.lane);
      end
    end
  end

  // Array has no reset: stored data survive everything but power
  always_ff @(posedge clk) begin
    if (do_wr) begin
      arr[wr.addr] <= sram_pkg::lane_merge(arr[wr.addr], wr.data, wr.lane,
                                           `LANE_W);
      par_arr[wr.addr] <= (par_arr[wr.addr] & ~wr.lane)
                          | (wr.par & wr.lane);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
      rpar <= '0;
    end else begin
      rdata <= next_rdata;
      rpar <= next_rpar;
    end
  end
endmodule

// ===== logic/sram_wr_buf.sv
module sram_wr_buf #(
  parameter int AW = 10,
  parameter int NB = 4
) (
  input wire logic clk,
  input wire logic rst,
  wr_stream_if.snk up,
  wr_stream_if.src dn
);
  localparam int W = AW + 10 * NB;

  logic [W-1:0] slot [2];
  logic [W-1:0] next_slot [2];
  logic [1:0] count;
  logic [1:0] next_count;
  logic wp;
  logic next_wp;
  logic rp;
  logic next_rp;
  logic [W-1:0] in_word;
  logic [W-1:0] out_word;
  logic store;
  logic unload;

  assign in_word = {up.addr, up.data, up.par, up.lane};
  assign up.ready = (count != 2'h2);
  // Empty buffer falls through so a write costs no extra cycle
  assign dn.valid = (count != 2'h0) || up.valid;
  assign out_word = (count != 2'h0) ? slot[rp] : in_word;
  assign {dn.addr, dn.data, dn.par, dn.lane} = out_word;

  // Store only what the drain side could not take at once
  always_comb begin
    store = up.valid && up.ready && !((count == 2'h0) && dn.ready);
    unload = dn.ready && (count != 2'h0);
    next_slot = slot;
    next_wp = wp;
    next_rp = rp;
    if (store) begin
      next_slot[wp] = in_word;
      next_wp = !wp;
    end
    if (unload) begin
      next_rp = !rp;
    end
    next_count = 2'(count + {1'b0, store} - {1'b0, unload});
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot[0] <= '0;
      slot[1] <= '0;
      count <= 2'h0;
      wp <= 1'b0;
      rp <= 1'b0;
    end else begin
      slot <= next_slot;
      count <= next_count;
      wp <= next_wp;
      rp <= next_rp;
    end
  end
endmodule

// ===== sim/sram_ctrl_model.sv
module sram_ctrl_model (
  input wire logic clk,
  input wire logic drive,
  input wire logic [35:0] wval,
  input wire logic [31:0] data_o,
  input wire logic data_oe,
  input wire logic [3:0] parity_o,
  input wire logic parity_oe,
  output logic [31:0] data_i,
  output logic [3:0] parity_i
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [35:0] last = 36'h0;

  // Device drivers win; a floating bus shows the inverse of its last value
  // so that a stale word can never pass for fresh write data
  always_comb begin
    data_i = data_oe ? data_o : (drive ? wval[31:0] : ~last[31:0]);
    parity_i = parity_oe ? parity_o : (drive ? wval[35:32] : ~last[35:32]);
  end

  // Remember what the bus carried for the released-bus pattern
  always @(posedge clk) begin
    last <= {parity_i, data_i};
  end
endmodule

// ===== sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst, cq_n, cs_a_n, cs_b, cs_c_n, step, wr_n, oe_n, zz, strap;
  logic [3:0] lane_n, par_i, par_o;
  logic [9:0] addr, a;
  logic [31:0] d_i, d_o, r;
  logic d_oe, p_oe, slp, drv, eoe;
  logic [35:0] wval;
  logic [35:0] mem [1024];
  logic [31:0] seed = 32'h45;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  bit desel = 1;

  sram_port #(.AW(10), .NB(4)) i_sram_port (.clk(clk), .rst(rst),
    .clk_qualify_n(cq_n), .chip_sel_a_n(cs_a_n), .chip_sel_b(cs_b),
    .chip_sel_c_n(cs_c_n), .burst_step_or_load(step), .wr_sel_n(wr_n),
    .byte_lane_wr_n(lane_n), .addr(addr), .out_en_n(oe_n), .sleep_req(zz),
    .burst_order_strap(strap), .data_i(d_i), .data_o(d_o), .data_oe(d_oe),
    .parity_i(par_i), .parity_o(par_o), .parity_oe(p_oe), .sleeping(slp));

  sram_ctrl_model i_sram_ctrl_model (.clk(clk), .drive(drv), .wval(wval),
    .data_o(d_o), .data_oe(d_oe), .parity_o(par_o), .parity_oe(p_oe),
    .data_i(d_i), .parity_i(par_i));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Low address bits of beat k from the start bits
  function automatic logic [1:0] beat_lo(logic [1:0] s, logic [1:0] k,
                                         logic il);
    if (il) begin
      return s ^ k;
    end
    return 2'(s + k);
  endfunction

  // Only lanes whose strobe is low take the new byte and parity bit
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n,
                                        logic [3:0] ln_n);
    logic [35:0] res;
    res = o;
    for (int i = 0; i < 4; i++) begin
      if (!ln_n[i]) begin
        res[8*i +: 8] = n[8*i +: 8];
        res[32+i] = n[32+i];
      end
    end
    return res;
  endfunction

  task automatic cmp_word(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Deselect cycles, each with a different select inactive
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      step = 1'b0;
      cs_a_n = (i % 3 == 0);
      cs_b = (i % 3 != 1);
      cs_c_n = (i % 3 == 2);
      @(negedge clk);
      desel = 1;
      cmp_bit(d_oe, 1'b0);
      cmp_bit(p_oe, 1'b0);
    end
  endtask

  // One burst of n beats, then one more command: deselect or empty step
  task automatic burst(input logic wr, input logic [9:0] st, input int n,
                       input logic full, input logic end_desel);
    logic [35:0] d, pd;
    logic [3:0] s, ps;
    logic [9:0] b, pb;
    logic [31:0] q;
    pd = 36'h0;
    ps = 4'hf;
    pb = st;
    for (int k = 0; k <= n; k++) begin
      q = rnd();
      b = {st[9:2], beat_lo(st[1:0], 2'(k), strap)};
      d = {q[3:0], rnd()};
      s = (full || k == n) ? {4{k == n}} : q[11:8];
      if (!wr && k > 0 && k < n && q[7]) begin
        // Masked edge in mid-burst, with a bogus load on the pins
        cq_n = 1'b1;
        step = 1'b0;
        cs_a_n = 1'b0;
        @(negedge clk);
        cmp_word({par_o, d_o}, mem[pb]);
        cmp_bit(d_oe, eoe);
        cq_n = 1'b0;
      end
      step = (k != 0) && !(k == n && end_desel);
      if (k == 0) begin
        cs_a_n = 1'b0;
        cs_b = 1'b1;
        cs_c_n = 1'b0;
        wr_n = ~wr;
        addr = st;
      end else if (k == n && end_desel) begin
        cs_a_n = 1'b1;
      end else begin
        {cs_a_n, cs_b, cs_c_n, wr_n} = q[15:12];
        addr = q[25:16];
      end
      lane_n = s;
      drv = wr && k > 0;
      wval = pd;
      @(negedge clk);
      if (wr && k > 0) begin
        mem[pb] = merge(mem[pb], pd, ps);
      end
      if (k == n && end_desel) begin
        desel = 1;
        cmp_bit(d_oe, 1'b0);
      end else if (wr) begin
        cmp_bit(d_oe, 1'b0);
      end else if (k < n) begin
        eoe = !desel && !oe_n;
        cmp_word({par_o, d_o}, mem[b]);
        cmp_bit(d_oe, eoe);
        cmp_bit(p_oe, eoe);
      end
      if (k == 0) begin
        desel = 0;
      end
      pb = b;
      pd = d;
      ps = s;
    end
    drv = 1'b0;
  endtask

  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    rst = 1'b1;
    {cq_n, cs_b, step, zz, drv} = 5'h0;
    {cs_a_n, cs_c_n, wr_n, strap} = 4'hf;
    lane_n = 4'hf;
    addr = 10'h0;
    oe_n = 1'b0;
    wval = 36'h0;
    a = 10'h0;
    eoe = 1'b0;
    repeat (3) @(negedge clk);
    cmp_bit(d_oe, 1'b0);
    rst = 1'b0;
    for (int t = 0; t < 24; t++) begin
      r = rnd();
      strap = (t == 0) ? 1'b1 : r[0];
      oe_n = (r[3:2] == 2'h0);
      a = r[17:8];
      idle(3);
      burst(1'b1, a, 4, 1'b1, r[6]);
      burst(1'b1, {a[9:2], r[21:20]}, int'(r[27:26]) + 1, 1'b0, r[4]);
      burst(1'b0, {a[9:2], r[23:22]}, 4, 1'b0, r[5]);
      $display("test %0d done", t);
    end
    // Sleep entry and exit keep the stored group intact
    idle(1);
    zz = 1'b1;
    @(negedge clk);
    cmp_bit(slp, 1'b0);
    // Two synchroniser edges, then two edges of entry, to the cycle
    repeat (2) @(negedge clk);
    cmp_bit(slp, 1'b0);
    @(negedge clk);
    cmp_bit(slp, 1'b1);
    zz = 1'b0;
    repeat (2) @(negedge clk);
    cmp_bit(slp, 1'b1);
    @(negedge clk);
    cmp_bit(slp, 1'b0);
    idle(2);
    burst(1'b0, a, 4, 1'b0, 1'b1);
    $display("test sleep done");
    complete_run();
  end
endmodule
